// *** sfm_monitor.sv ***
// sfm_monitor: port-level checks on sfm_top.
// assumes it is bound into sfm_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sfm_monitor (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] sense_source_select_i,
    input wire logic sense_select_write_i,
    input wire logic driver_switch_on_i,
    input wire logic fault_clear_cmd_i,
    input wire logic fault_clear_cmd_o,
    input wire logic sleep_bar_input_i,
    input wire logic logic_supply_reset_i,
    input wire logic pump_undervolt_i,
    input wire logic overvolt_low_cmp_i,
    input wire logic overvolt_high_cmp_i,
    input wire logic overvolt_level_select_i,
    input wire sfm_pkg::sfm_sense_ctrl_t sense_ctrl_o,
    input wire sfm_pkg::sfm_status_t chip_status_one_o,
    input wire sfm_pkg::sfm_drive_t drive_o,
    input wire logic electrochromic_driver_enable_o,
    input wire logic heater_enable_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence restart_s;
        sense_select_write_i && drive_o.device_active;
    endsequence
    sequence zero_blank_s;
        sense_ctrl_o.output_zero && sense_ctrl_o.blanked;
    endsequence
    // flag rises two edges after the qualified comparator
    sequence ov_low_held_s;
        $past(overvolt_low_cmp_i, 2) && $rose(chip_status_one_o.overvolt_low_flag);
    endsequence
    sequence clear_ack_s;
        ##1 fault_clear_cmd_o ##1 !fault_clear_cmd_o;
    endsequence
    restart_zero_a: assert property (
        restart_s |-> ##[1:2] zero_blank_s)
        else $error("sense output not zeroed after select write");
    switch_blank_a: assert property (
        driver_switch_on_i && drive_o.device_active |-> ##[1:2] sense_ctrl_o.blanked)
        else $error("sense output not blanked after driver switch-on");
    por_clear_a: assert property (
        $rose(fault_clear_cmd_i) && !logic_supply_reset_i |-> ##[1:3] !chip_status_one_o.por)
        else $error("power-on flag not cleared by fault clear");
    clear_ack_a: assert property (
        $rose(fault_clear_cmd_i) |-> clear_ack_s)
        else $error("fault clear bit not returned to zero");
    reserved_none_a: assert property (
        (sense_source_select_i == 5'h0d)[*4] |-> sense_ctrl_o.src == sfm_pkg::SFM_SRC_NONE)
        else $error("reserved select code routed a source");
    pump_no_supply_a: assert property (
        pump_undervolt_i[*3] |-> sense_ctrl_o.src != sfm_pkg::SFM_SRC_SUPPLY)
        else $error("supply sense routed during pump undervoltage");
    sleep_off_a: assert property (
        (!sleep_bar_input_i)[*6] |-> !drive_o.device_active && !drive_o.pump_enable)
        else $error("device active while sleep input low");
    uv_response_a: assert property (
        $rose(chip_status_one_o.motor_supply_undervolt_flag)
        |-> drive_o.gate_pulldown && !drive_o.pump_enable)
        else $error("undervoltage without pulldown and pump off");
    ov_low_stop_a: assert property (
        ov_low_held_s |-> !drive_o.high_side_enable
        && !electrochromic_driver_enable_o && !heater_enable_o)
        else $error("high-side group still on above low threshold");
    ov_bridge_stop_a: assert property (
        ov_low_held_s and !overvolt_level_select_i |-> !drive_o.half_bridge_enable)
        else $error("half-bridges still on at level zero");
    ov_high_cause_a: assert property (
        $rose(chip_status_one_o.overvolt_high_flag)
        |-> $past(overvolt_high_cmp_i, 2) && overvolt_level_select_i)
        else $error("high overvoltage flag without qualified cause");
endmodule : sfm_monitor
bind sfm_top sfm_monitor u_sfm_monitor (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .sense_source_select_i(sense_source_select_i), .sense_select_write_i(sense_select_write_i),
    .driver_switch_on_i(driver_switch_on_i), .fault_clear_cmd_i(fault_clear_cmd_i),
    .fault_clear_cmd_o(fault_clear_cmd_o),
    .sleep_bar_input_i(sleep_bar_input_i), .logic_supply_reset_i(logic_supply_reset_i),
    .pump_undervolt_i(pump_undervolt_i), .overvolt_low_cmp_i(overvolt_low_cmp_i),
    .overvolt_high_cmp_i(overvolt_high_cmp_i), .overvolt_level_select_i(overvolt_level_select_i),
    .sense_ctrl_o(sense_ctrl_o), .chip_status_one_o(chip_status_one_o), .drive_o(drive_o),
    .electrochromic_driver_enable_o(electrochromic_driver_enable_o),
    .heater_enable_o(heater_enable_o));
`default_nettype wire

// *** sfm_pkg.sv ***
// sfm_pkg: constants and carrier types for the supply fault and sense mux block.
// assumes a single 250 MHz core clock; it depends on no other file.
package sfm_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // times in ns
    localparam int unsigned SENSE_RESET_NS = 5500;
    localparam int unsigned SENSE_BLANK_NS = 60000;
    // reset is a longest time (round down), blank a least time (round up)
    localparam int unsigned SENSE_RESET_CYC = (SENSE_RESET_NS * CLK_MHZ) / 1000;
    localparam int unsigned SENSE_BLANK_CYC = (SENSE_BLANK_NS * CLK_MHZ + 999) / 1000;
    // deglitch counts (cycles), plain defaults
    localparam int unsigned DG_LOGIC_CYC = 16;
    localparam int unsigned DG_UV_CYC = 16;
    localparam int unsigned DG_OV_HIGH_CYC = 16;
    localparam int unsigned DG_THERM_CYC = 16;
    localparam int unsigned DG_OV_LOW_SHORT_CYC = 8;
    localparam int unsigned DG_OV_LOW_LONG_CYC = 64;
    localparam int unsigned DG_CNT_W = 8;
    localparam int unsigned SEL_W = 5;
    localparam logic [4:0] SEL_NONE = 5'h00;
    localparam logic [4:0] SEL_OUT_FIRST = 5'h01;
    localparam logic [4:0] SEL_OUT_LAST = 5'h0c;
    localparam logic [4:0] SEL_SUPPLY_NOM = 5'h10;
    localparam logic [4:0] SEL_THERM_FIRST = 5'h11;
    localparam logic [4:0] SEL_THERM_LAST = 5'h14;
    localparam logic [4:0] SEL_SUPPLY_HIGH = 5'h15;

    typedef enum logic [1:0] {
        SFM_SRC_NONE,
        SFM_SRC_CURRENT,
        SFM_SRC_SUPPLY,
        SFM_SRC_THERMAL
    } sfm_src_t;

    // analog mux steering
    typedef struct packed {
        logic output_zero;
        logic blanked;
        sfm_src_t src;
        logic [3:0] index;
        logic supply_high_range;
    } sfm_sense_ctrl_t;

    // chip_status_one flags
    typedef struct packed {
        logic fault;
        logic por;
        logic motor_supply_undervolt_flag;
        logic overvolt_low_flag;
        logic overvolt_high_flag;
        logic pump_undervolt_flag;
    } sfm_status_t;

    // drive enables
    typedef struct packed {
        logic device_active;
        logic pump_enable;
        logic gate_pulldown;
        logic half_bridge_enable;
        logic high_side_enable;
    } sfm_drive_t;
endpackage : sfm_pkg

// *** sfm_top.sv ***
// sfm_top: sense source mux control and supply fault logic.
// assumes comparator inputs are synchronous to core_clk_i; the fault-clear
// command is a level written by the host and cleared here.
`timescale 1ns/1ps
`default_nettype none

module sfm_top #(
    parameter int unsigned DG_W = sfm_pkg::DG_CNT_W
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] sense_source_select_i,
    input wire logic sense_select_write_i,
    input wire logic driver_switch_on_i,
    input wire logic fault_clear_cmd_i,
    input wire logic sleep_bar_input_i,
    input wire logic logic_supply_reset_i,
    input wire logic motor_supply_uv_cmp_i,
    input wire logic overvolt_low_cmp_i,
    input wire logic overvolt_high_cmp_i,
    input wire logic pump_undervolt_i,
    input wire logic thermal_shutdown_cmp_i,
    input wire logic undervolt_recovery_mode_i,
    input wire logic overvolt_recovery_mode_i,
    input wire logic overvolt_level_select_i,
    input wire logic overvolt_deglitch_select_i,
    input wire logic thermal_shutdown_scope_i,
    output logic fault_clear_cmd_o,
    output sfm_pkg::sfm_sense_ctrl_t sense_ctrl_o,
    output sfm_pkg::sfm_status_t chip_status_one_o,
    output sfm_pkg::sfm_drive_t drive_o,
    output logic electrochromic_driver_enable_o,
    output logic heater_enable_o
);
    localparam int unsigned NCMP = 5;
    localparam logic [DG_W-1:0] DG_LEN [NCMP] = '{
        DG_W'(sfm_pkg::DG_LOGIC_CYC), DG_W'(sfm_pkg::DG_UV_CYC),
        DG_W'(sfm_pkg::DG_OV_LOW_SHORT_CYC), DG_W'(sfm_pkg::DG_OV_HIGH_CYC),
        DG_W'(sfm_pkg::DG_THERM_CYC)};
    localparam int unsigned TW = 16;

    logic rst_sync1_reg;
    logic rst_sync2_reg;
    logic rst_n;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync1_reg <= 1'b0;
            rst_sync2_reg <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_sync2_reg <= rst_sync1_reg;
        end
    end
    assign rst_n = rst_sync2_reg;

    // deglitch filters
    logic [NCMP-1:0] raw;
    logic [NCMP-1:0] qual;
    logic [DG_W-1:0] ov_low_len;
    assign raw = {thermal_shutdown_cmp_i, overvolt_high_cmp_i, overvolt_low_cmp_i,
                  motor_supply_uv_cmp_i, logic_supply_reset_i};
    assign ov_low_len = overvolt_deglitch_select_i ? DG_W'(sfm_pkg::DG_OV_LOW_LONG_CYC)
                                                   : DG_W'(sfm_pkg::DG_OV_LOW_SHORT_CYC);

    genvar gi;
    generate
        for (gi = 0; gi < NCMP; gi++) begin : g_dg
            logic [DG_W-1:0] cnt_reg;
            logic q_reg;
            logic [DG_W-1:0] len;
            assign len = (gi == 2) ? ov_low_len : DG_LEN[gi];
            // qualify only after the level holds for len cycles
            always_ff @(posedge core_clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    cnt_reg <= '0;
                    q_reg <= 1'b0;
                end else if (raw[gi] == q_reg) begin
                    cnt_reg <= '0;
                end else if (cnt_reg + 1'b1 >= len) begin
                    cnt_reg <= '0;
                    q_reg <= raw[gi];
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
            assign qual[gi] = q_reg;
        end
    endgenerate

    logic logic_reset_q;
    logic uv_q;
    logic ovl_q;
    logic ovh_q;
    logic therm_q;
    assign {therm_q, ovh_q, ovl_q, uv_q, logic_reset_q} = qual;

    logic inactive;
    logic global_therm;
    logic clear_pulse;
    assign inactive = logic_reset_q | ~sleep_bar_input_i;
    assign global_therm = therm_q & ~thermal_shutdown_scope_i;

    // fault-clear acts in the first cycle it is seen, then reads back zero;
    // a held bit never clears twice, the host must drop it to re-arm
    logic clr_busy_reg;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clr_busy_reg <= 1'b0;
        end else begin
            clr_busy_reg <= fault_clear_cmd_i;
        end
    end
    assign clear_pulse = fault_clear_cmd_i & ~clr_busy_reg;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fault_clear_cmd_o <= 1'b0;
        end else begin
            fault_clear_cmd_o <= clear_pulse;
        end
    end

    // latched flags; a new event wins over a clear
    logic por_reg;
    logic uv_flag_reg;
    logic ovl_flag_reg;
    logic ovh_flag_reg;
    logic pump_flag_reg;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            por_reg <= 1'b1;
            uv_flag_reg <= 1'b0;
            ovl_flag_reg <= 1'b0;
            ovh_flag_reg <= 1'b0;
            pump_flag_reg <= 1'b0;
        end else begin
            por_reg <= logic_reset_q | (por_reg & ~clear_pulse);
            uv_flag_reg <= (uv_q & ~inactive) | (uv_flag_reg & ~clear_pulse);
            ovl_flag_reg <= (ovl_q & ~inactive) | (ovl_flag_reg & ~clear_pulse);
            ovh_flag_reg <= (ovh_q & ovl_q & overvolt_level_select_i & ~inactive)
                            | (ovh_flag_reg & ~clear_pulse);
            pump_flag_reg <= (pump_undervolt_i & ~inactive) | (pump_flag_reg & ~clear_pulse);
        end
    end

    // latched fault states for latched recovery modes
    logic uv_hold_reg;
    logic ov_hold_reg;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            uv_hold_reg <= 1'b0;
        end else if (uv_q & ~inactive) begin
            uv_hold_reg <= ~undervolt_recovery_mode_i;
        end else if (clear_pulse | undervolt_recovery_mode_i) begin
            uv_hold_reg <= 1'b0;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ov_hold_reg <= 1'b0;
        end else if (ovl_q & ~inactive) begin
            ov_hold_reg <= ~overvolt_recovery_mode_i;
        end else if (clear_pulse | overvolt_recovery_mode_i) begin
            ov_hold_reg <= 1'b0;
        end
    end

    // at level one bridges latch only on a high-threshold event; at level zero they latch through ov_hold_reg
    logic ovh_hold_reg;
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ovh_hold_reg <= 1'b0;
        end else if (ovh_q & ovl_q & overvolt_level_select_i & ~inactive) begin
            ovh_hold_reg <= ~overvolt_recovery_mode_i;
        end else if (clear_pulse | overvolt_recovery_mode_i) begin
            ovh_hold_reg <= 1'b0;
        end
    end

    logic uv_active;
    logic ov_active;
    logic bridge_ov;
    assign uv_active = (uv_q | uv_hold_reg) & ~inactive;
    assign ov_active = (ovl_q | ov_hold_reg) & ~inactive;
    // level one lets bridges run between thresholds
    assign bridge_ov = overvolt_level_select_i ? (ovh_q | ovh_hold_reg)
                                               : ov_active;

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            drive_o <= '0;
            electrochromic_driver_enable_o <= 1'b0;
            heater_enable_o <= 1'b0;
        end else begin
            drive_o.device_active <= ~inactive & ~global_therm;
            drive_o.pump_enable <= ~inactive & ~global_therm & ~uv_active;
            drive_o.gate_pulldown <= uv_active;
            drive_o.half_bridge_enable <= ~inactive & ~global_therm & ~uv_active
                                          & ~bridge_ov;
            drive_o.high_side_enable <= ~inactive & ~global_therm & ~uv_active
                                        & ~ov_active;
            electrochromic_driver_enable_o <= ~inactive & ~global_therm & ~uv_active
                                              & ~ov_active;
            heater_enable_o <= ~inactive & ~global_therm & ~uv_active & ~ov_active;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            chip_status_one_o <= '0;
        end else begin
            chip_status_one_o.fault <= uv_active | ov_active;
            chip_status_one_o.por <= por_reg;
            chip_status_one_o.motor_supply_undervolt_flag <= uv_flag_reg;
            chip_status_one_o.overvolt_low_flag <= ovl_flag_reg;
            chip_status_one_o.overvolt_high_flag <= ovh_flag_reg;
            chip_status_one_o.pump_undervolt_flag <= pump_flag_reg;
        end
    end

    // sense path timing: reset interval and longer blanking interval, both started together on a restart
    logic [4:0] sel_reg;
    logic [TW-1:0] zero_cnt_reg;
    logic [TW-1:0] blank_cnt_reg;
    logic restart;
    assign restart = sense_select_write_i | (sense_source_select_i != sel_reg);

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= sfm_pkg::SEL_NONE;
            zero_cnt_reg <= '0;
            blank_cnt_reg <= '0;
        end else begin
            sel_reg <= sense_source_select_i;
            if (restart) begin
                zero_cnt_reg <= TW'(sfm_pkg::SENSE_RESET_CYC);
                blank_cnt_reg <= TW'(sfm_pkg::SENSE_BLANK_CYC);
            end else begin
                if (zero_cnt_reg != '0) begin
                    zero_cnt_reg <= zero_cnt_reg - 1'b1;
                end
                if (driver_switch_on_i) begin
                    blank_cnt_reg <= TW'(sfm_pkg::SENSE_BLANK_CYC);
                end else if (blank_cnt_reg != '0) begin
                    blank_cnt_reg <= blank_cnt_reg - 1'b1;
                end
            end
        end
    end

    sfm_pkg::sfm_sense_ctrl_t sense_next;
    always_comb begin
        sense_next = '0;
        if (sel_reg >= sfm_pkg::SEL_OUT_FIRST && sel_reg <= sfm_pkg::SEL_OUT_LAST) begin
            sense_next.src = sfm_pkg::SFM_SRC_CURRENT;
            sense_next.index = 4'(sel_reg - sfm_pkg::SEL_OUT_FIRST);
        end else if (sel_reg >= sfm_pkg::SEL_THERM_FIRST
                     && sel_reg <= sfm_pkg::SEL_THERM_LAST) begin
            sense_next.src = sfm_pkg::SFM_SRC_THERMAL;
            sense_next.index = 4'(sel_reg - sfm_pkg::SEL_THERM_FIRST);
        end else if ((sel_reg == sfm_pkg::SEL_SUPPLY_NOM || sel_reg == sfm_pkg::SEL_SUPPLY_HIGH)
                     && !pump_undervolt_i && !global_therm) begin
            sense_next.src = sfm_pkg::SFM_SRC_SUPPLY;
            sense_next.supply_high_range = (sel_reg == sfm_pkg::SEL_SUPPLY_HIGH);
        end
        sense_next.output_zero = restart || zero_cnt_reg != '0
                                 || sense_next.src == sfm_pkg::SFM_SRC_NONE || inactive;
        sense_next.blanked = restart || blank_cnt_reg != '0 || driver_switch_on_i;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sense_ctrl_o <= '{output_zero: 1'b1, blanked: 1'b1, src: sfm_pkg::SFM_SRC_NONE,
                              index: 4'h0, supply_high_range: 1'b0};
        end else begin
            sense_ctrl_o <= sense_next;
        end
    end
endmodule : sfm_top

`default_nettype wire

// *** sfm_top_bench.sv ***
// sfm_top_bench: directed sense mux and supply fault tests.
// assumes sfm_pkg and sfm_monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sfm_top_bench;
    logic clk, rst_n, wr, drv_on, clr, slp_n, lrst, uv, ovl, ovh, pump, th;
    logic uv_mode, ov_mode, ov_lvl, ov_dg, scope, clr_o, ec, heat;
    logic [4:0] sel;
    sfm_pkg::sfm_sense_ctrl_t sc;
    sfm_pkg::sfm_status_t st;
    sfm_pkg::sfm_drive_t dr;
    int failures = 0;
    int compares = 0;
    sfm_top u_sfm_top (.core_clk_i(clk), .rst_n_i(rst_n), .sense_source_select_i(sel),
        .sense_select_write_i(wr), .driver_switch_on_i(drv_on), .fault_clear_cmd_i(clr),
        .sleep_bar_input_i(slp_n), .logic_supply_reset_i(lrst), .motor_supply_uv_cmp_i(uv),
        .overvolt_low_cmp_i(ovl), .overvolt_high_cmp_i(ovh), .pump_undervolt_i(pump),
        .thermal_shutdown_cmp_i(th), .undervolt_recovery_mode_i(uv_mode),
        .overvolt_recovery_mode_i(ov_mode), .overvolt_level_select_i(ov_lvl),
        .overvolt_deglitch_select_i(ov_dg), .thermal_shutdown_scope_i(scope),
        .fault_clear_cmd_o(clr_o), .sense_ctrl_o(sc), .chip_status_one_o(st), .drive_o(dr),
        .electrochromic_driver_enable_o(ec), .heater_enable_o(heat));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // command is a level; dropping it re-arms the next clear
    task automatic clear_faults();
        clr = 1'b1;
        cyc(1);
        chk("cmd", clr_o, 1'b1);
        clr = 1'b0;
        cyc(3);
    endtask : clear_faults
    task automatic write_sel(input logic [4:0] code);
        sel = code;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
        chk("zero", sc.output_zero, 1'b1);
        chk("blank", sc.blanked, 1'b1);
        cyc(sfm_pkg::SENSE_RESET_CYC + 4);
    endtask : write_sel
    function automatic logic [1:0] exp_src(input int c);
        if (c >= 1 && c <= 12) return sfm_pkg::SFM_SRC_CURRENT;
        if (c == 16 || c == 21) return sfm_pkg::SFM_SRC_SUPPLY;
        if (c >= 17 && c <= 20) return sfm_pkg::SFM_SRC_THERMAL;
        return sfm_pkg::SFM_SRC_NONE;
    endfunction : exp_src
    task automatic wrap_up();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // about 50k cycles expected; give up at 75k
    initial begin
        #300000;
        failures++;
        wrap_up();
    end
    initial begin
        {rst_n, wr, drv_on, clr, lrst, uv, ovl, ovh, pump, th} = '0;
        {uv_mode, ov_mode, ov_lvl, ov_dg, scope} = '0;
        slp_n = 1'b1;
        sel = 5'h00;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cyc(4);
        chk("por", st.por, 1'b1);
        clear_faults();
        chk("por", st.por, 1'b0);
        chk("cmd", clr_o, 1'b0);
        $display("test reset done");
        for (int c = 0; c <= 22; c++) begin
            write_sel(c[4:0]);
            chk("src", sc.src, exp_src(c));
            chk("zero", sc.output_zero, exp_src(c) == sfm_pkg::SFM_SRC_NONE);
            if (c == 16 || c == 21) chk("range", sc.supply_high_range, c == 21);
            if (c >= 17 && c <= 20) chk("index", sc.index, 4'(c - 17));
            if (c >= 1 && c <= 12) chk("index", sc.index, 4'(c - 1));
        end
        chk("blank", sc.blanked, 1'b1);
        cyc(sfm_pkg::SENSE_BLANK_CYC);
        chk("blank", sc.blanked, 1'b0);
        drv_on = 1'b1;
        cyc(1);
        drv_on = 1'b0;
        cyc(1);
        chk("blank", sc.blanked, 1'b1);
        pump = 1'b1;
        write_sel(5'h10);
        chk("src", sc.src, sfm_pkg::SFM_SRC_NONE);
        chk("pumpflag", st.pump_undervolt_flag, 1'b1);
        pump = 1'b0;
        cyc(2);
        chk("src", sc.src, sfm_pkg::SFM_SRC_SUPPLY);
        $display("test sense done");
        uv = 1'b1;
        cyc(30);
        chk("pulldown", dr.gate_pulldown, 1'b1);
        chk("pump", dr.pump_enable, 1'b0);
        chk("uv", {st.fault, st.motor_supply_undervolt_flag}, 2'b11);
        uv = 1'b0;
        cyc(30);
        chk("fault", {st.fault, dr.half_bridge_enable}, 2'b10);
        clear_faults();
        chk("fault", {st.fault, dr.half_bridge_enable}, 2'b01);
        chk("pumpflag", st.pump_undervolt_flag, 1'b0);
        uv_mode = 1'b1;
        uv = 1'b1;
        cyc(30);
        uv = 1'b0;
        cyc(30);
        chk("uv", {st.fault, st.motor_supply_undervolt_flag}, 2'b01);
        clear_faults();
        chk("uv", st.motor_supply_undervolt_flag, 1'b0);
        $display("test undervolt done");
        ovl = 1'b1;
        cyc(30);
        chk("ov", {st.fault, st.overvolt_low_flag, st.overvolt_high_flag}, 3'b110);
        chk("drv", {dr.half_bridge_enable, dr.high_side_enable, ec, heat}, 4'h0);
        ovl = 1'b0;
        cyc(30);
        chk("fault", st.fault, 1'b1);
        chk("hold", {dr.half_bridge_enable, dr.high_side_enable}, 2'b00);
        clear_faults();
        {ov_lvl, ov_mode, ovl} = 3'b111;
        cyc(30);
        chk("drv", {st.fault, dr.half_bridge_enable, dr.high_side_enable}, 3'b110);
        ovh = 1'b1;
        cyc(30);
        chk("drv", {dr.half_bridge_enable, st.overvolt_high_flag}, 2'b01);
        {ovl, ovh} = 2'b00;
        cyc(30);
        chk("auto", {st.fault, st.overvolt_low_flag, dr.high_side_enable}, 3'b011);
        clear_faults();
        ov_dg = 1'b1;
        ovl = 1'b1;
        cyc(30);
        chk("dg", st.overvolt_low_flag, 1'b0);
        cyc(60);
        chk("dg", st.overvolt_low_flag, 1'b1);
        ovl = 1'b0;
        // the long filter also holds the condition after the pin drops
        cyc(70);
        clear_faults();
        chk("dg", st.overvolt_low_flag, 1'b0);
        $display("test overvolt done");
        slp_n = 1'b0;
        cyc(10);
        chk("sleep", {dr.device_active, dr.pump_enable}, 2'b00);
        slp_n = 1'b1;
        cyc(10);
        chk("wake", dr.device_active, 1'b1);
        lrst = 1'b1;
        cyc(40);
        chk("lrst", dr.device_active, 1'b0);
        lrst = 1'b0;
        cyc(40);
        chk("lrst", dr.device_active, 1'b1);
        chk("por", st.por, 1'b1);
        th = 1'b1;
        cyc(30);
        chk("therm", dr.device_active, 1'b0);
        $display("test shutdown done");
        wrap_up();
    end
endmodule : sfm_top_bench
`default_nettype wire
